// File: shared/svc_regs.svh
// timing counts and register offsets shared by both ends of the services link
// assumes a 20 MHz core clock; included by bare name
`ifndef SVC_REGS_SVH
`define SVC_REGS_SVH
`define CLK_HZ 20000000
`define REF_HZ 5000000
`define RESET_HOLD_MS 100
`define REF_DIV (`CLK_HZ / `REF_HZ)
`define RESET_HOLD_CYC ((`CLK_HZ / 1000) * `RESET_HOLD_MS)
`define REF_PER_INTERVAL ((`REF_HZ / 1000) * `RESET_HOLD_MS)
`define DS_CTRL_ADDR 4'h0
`define DS_STAT_ADDR 4'h1
`define IRQ_STAT_ADDR 4'h2
`define IRQ_MASK_ADDR 4'h3
`define HOST_CTRL_ADDR 4'h4
`define HOST_STAT_ADDR 4'h5
`define BOOT_ACCEPT_BIT 0
`define HALT_ENTER_BIT 1
`define FAULT_BIT 2
`define DS_FAULT_BIT 3
`endif

// File: shared/svc_pkg.sv
// types shared by both ends of the services link
// assumes nothing beyond the compiler
package svc_pkg;
  typedef enum logic [4:0] {
    ST_BOOT_WAIT = 5'h01,
    ST_RUN = 5'h02,
    ST_HALT = 5'h04,
    ST_RESET = 5'h08,
    ST_IDLE = 5'h10
  } dev_state_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_HOLD = 4'h2,
    HS_SETTLE = 4'h4,
    HS_READY = 4'h8
  } host_state_t;
  typedef logic [3:0] lane_t;
endpackage : svc_pkg

// File: shared/svc_if.sv
// pins between the host controller and the module services logic
// the open-drain fault line resolves here with a pull-up
`timescale 1ns/1ps
interface svc_if;
  logic ref_tick;
  logic reset_pin;
  logic analyse_pin;
  logic first_rate_select;
  logic other_rates_select;
  logic [3:0] serial_port_rx;
  logic [3:0] serial_port_tx;
  logic fault_out_n_oe_n;
  wire fault_out_n;
  // released line reads high through the pull-up
  assign fault_out_n = fault_out_n_oe_n ? 1'b1 : 1'b0;
  modport dev (input ref_tick, input reset_pin, input analyse_pin,
    input first_rate_select, input other_rates_select,
    input serial_port_rx, output serial_port_tx,
    output fault_out_n_oe_n);
  modport host (output ref_tick, output reset_pin, output analyse_pin,
    output first_rate_select, output other_rates_select,
    output serial_port_rx, input serial_port_tx, input fault_out_n);
endinterface : svc_if

// File: core/pin_sync.sv
// three-stage synchroniser with agreement filter for pins
// assumes a single core_clk domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a bit changes only once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        level[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        level[i] <= s3_q[i];
      end
    end
  end
endmodule : pin_sync

// File: core/svc_host.sv
// host controller end: sequences reset and analyse and picks link rates
// assumes svc_if carries the pins and software uses the plain port
`timescale 1ns/1ps
`include "svc_regs.svh"
module svc_host #(
  parameter int HOLD_CYC = `RESET_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  svc_if.host link,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic link_ready,
  output logic [3:0] tx_lanes_seen
);
  import svc_pkg::*;
  host_state_t st_q;
  logic [31:0] cnt_q;
  logic [1:0] div_q;
  logic [1:0] rate_q;
  logic halt_req_q;
  logic fault_seen; // wired fault line seen low
  logic [3:0] tx_sync;
  // the fault line is inverted before syncing so that the synchroniser's
  // reset value reads as no fault rather than a line pulled low
  pin_sync #(.W(5)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin({~link.fault_out_n, link.serial_port_tx}),
    .level({fault_seen, tx_sync})
  );
  // 5 MHz reference as a divided level
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign link.ref_tick = div_q[1];
  // control writes: bit0 start reset, bit1 analyse, bits3:2 rates
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rate_q <= 2'h0;
      halt_req_q <= 1'b0;
    end else if (wr && addr == `HOST_CTRL_ADDR) begin
      rate_q <= wdata[3:2];
      halt_req_q <= wdata[1];
    end
  end
  assign link.first_rate_select = rate_q[0];
  assign link.other_rates_select = rate_q[1];
  // reset hold then settle, each a full interval
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= HS_IDLE;
      cnt_q <= 32'h0;
    end else begin
      case (st_q)
        HS_IDLE: if (wr && addr == `HOST_CTRL_ADDR && wdata[0]) begin
          st_q <= HS_HOLD;
          cnt_q <= 32'h0;
        end
        HS_HOLD: if (cnt_q == 32'(HOLD_CYC - 1)) begin
          st_q <= HS_SETTLE;
          cnt_q <= 32'h0;
        end else cnt_q <= cnt_q + 32'h1;
        HS_SETTLE: if (cnt_q == 32'(HOLD_CYC - 1)) begin
          st_q <= HS_READY;
        end else cnt_q <= cnt_q + 32'h1;
        HS_READY: if (wr && addr == `HOST_CTRL_ADDR && wdata[0]) begin
          st_q <= HS_HOLD;
          cnt_q <= 32'h0;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end
  assign link.reset_pin = (st_q == HS_HOLD);
  assign link.analyse_pin = halt_req_q;
  assign link_ready = (st_q == HS_READY);
  // no link traffic until the settle interval is over
  assign link.serial_port_rx = link_ready ? 4'hF : 4'h0;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) tx_lanes_seen <= 4'h0;
    else tx_lanes_seen <= tx_sync;
  end
  // status: bit0 ready, bit1 fault line low (wired-or), bits7:4 state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rdata <= 8'h00;
    else if (rd && addr == `HOST_STAT_ADDR)
      rdata <= {st_q, 2'h0, fault_seen, link_ready};
    else rdata <= 8'h00;
  end
endmodule : svc_host

// File: core/svc_dev.sv
// module services end: boot wait, halt, fault driver, downstream port
// assumes svc_if pins from the host and a plain register port
`timescale 1ns/1ps
`include "svc_regs.svh"
module svc_dev (
  input wire logic core_clk,
  input wire logic resetn,
  svc_if.dev link,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic internal_error,
  output logic booted,
  output logic halted,
  output logic bus_enable,
  output logic [1:0] port_fast,
  output logic [3:0] port_answer,
  output logic downstream_reset_out,
  output logic downstream_halt_out,
  input wire logic downstream_fault_in_n,
  output logic irq
);
  import svc_pkg::*;
  dev_state_t st_q;
  logic rst_s, ana_s, ref_s, ds_fault_n_s;
  logic ds_fault_s;
  logic ref_rise;
  logic [1:0] rate_s;
  logic [3:0] rx_s;
  logic [3:0] stat_q, mask_q;
  logic [3:0] ev;
  logic [1:0] ds_q;
  logic [3:0] state_keep_q;
  logic ref_prev_q;
  // the downstream fault pin is inverted before syncing; a raw active-low
  // pin would read as a fault for the first cycles after reset and set
  // a false sticky event
  pin_sync #(.W(10)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin({link.reset_pin, link.analyse_pin, link.ref_tick,
      ~downstream_fault_in_n, link.other_rates_select,
      link.first_rate_select, link.serial_port_rx}),
    .level({rst_s, ana_s, ref_s, ds_fault_s, rate_s, rx_s})
  );
  assign ds_fault_n_s = ~ds_fault_s;

  // reference edge seen as a one-cycle enable for internal clocks;
  // the core clock is four times the reference, so each rising edge
  // of the synced level marks one reference period
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) ref_prev_q <= 1'b0;
    else ref_prev_q <= ref_s;
  end
  assign ref_rise = ref_s & ~ref_prev_q;

  // rate pins: low slow, high fast, per group
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) port_fast <= 2'h0;
    else port_fast <= rate_s;
  end
  // state: reset enters boot wait unless analyse asks for a halt;
  // a halt is left only by a reset without analyse, so the host may
  // interrogate a stopped processor for as long as it needs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_BOOT_WAIT;
    end else begin
      case (st_q)
        ST_BOOT_WAIT: begin
          if (rst_s) begin
            st_q <= ana_s ? ST_HALT : ST_RESET;
          end else if (|rx_s) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN, ST_IDLE: begin
          if (rst_s) begin
            st_q <= ana_s ? ST_HALT : ST_RESET;
          end
        end
        ST_HALT: begin
          // analyse still high keeps the halt; reset alone clears it
          if (rst_s && !ana_s) begin
            st_q <= ST_RESET;
          end
        end
        ST_RESET: begin
          if (!rst_s) begin
            st_q <= ST_BOOT_WAIT;
          end
        end
        default: begin
          st_q <= ST_BOOT_WAIT;
        end
      endcase
    end
  end

  // processor state kept across a halt, cleared by plain reset; it
  // advances once per reference period while the processor runs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_keep_q <= 4'h0;
    end else if (st_q == ST_RESET) begin
      state_keep_q <= 4'h0;
    end else if (st_q == ST_RUN && ref_rise) begin
      state_keep_q <= state_keep_q + 4'h1;
    end
  end

  // run and halt flags follow the state directly
  assign booted = (st_q == ST_RUN);
  assign halted = (st_q == ST_HALT);
  assign bus_enable = booted;

  // each port answers on its own: a halted processor echoes the
  // interrogation, a running one shows its kept state
  genvar p;
  for (p = 0; p < 4; p++) begin : g_port
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        port_answer[p] <= 1'b0;
      end else if (st_q == ST_HALT) begin
        port_answer[p] <= rx_s[p];
      end else if (st_q == ST_RUN) begin
        port_answer[p] <= state_keep_q[p];
      end else begin
        port_answer[p] <= 1'b0;
      end
    end
  end
  assign link.serial_port_tx = port_answer;

  // open drain: enable low means pulling low; the output never drives
  // high, so several modules may share one pulled-up fault line and
  // any of them can pull it down
  assign link.fault_out_n_oe_n = ~internal_error;


  // downstream control: bit0 reset, bit1 analyse, same polarity as the
  // module's own pins, so a register one asserts the downstream pin;
  // a plain reset of this module clears both
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) ds_q <= 2'h0;
    else if (st_q == ST_RESET) ds_q <= 2'h0;
    else if (wr && addr == `DS_CTRL_ADDR) ds_q <= wdata[1:0];
  end
  assign downstream_reset_out = ds_q[0];
  assign downstream_halt_out = ds_q[1];

  // event sources: boot accepted, halt entered, internal error and
  // downstream fault, in the order of the status bits
  assign ev = {ds_fault_s, internal_error,
    (st_q != ST_HALT) & rst_s & ana_s,
    (st_q == ST_BOOT_WAIT) & (|rx_s) & !rst_s};

  // sticky bits, one flop each; set wins over a write-one clear so an
  // event that lands in the clearing cycle is never lost
  genvar b;
  for (b = 0; b < 4; b++) begin : g_stat
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        stat_q[b] <= 1'b0;
      end else if (ev[b]) begin
        stat_q[b] <= 1'b1;
      end else if (wr && addr == `IRQ_STAT_ADDR && wdata[b]) begin
        stat_q[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) mask_q <= 4'h0;
    else if (wr && addr == `IRQ_MASK_ADDR) mask_q <= wdata[3:0];
  end
  assign irq = |(stat_q & mask_q);

  // read data stands the cycle after the strobe only and is zero
  // otherwise, so the read buses of both ends may simply be or-ed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        `DS_CTRL_ADDR: rdata <= {6'h00, ds_q};
        `DS_STAT_ADDR: rdata <= {st_q, 2'h0, ds_fault_n_s};
        `IRQ_STAT_ADDR: rdata <= {4'h0, stat_q};
        `IRQ_MASK_ADDR: rdata <= {4'h0, mask_q};
        default: rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end
endmodule : svc_dev

// File: test/svc_props.sv
// checker for the services link pins between host and module ends
// assumes it is instantiated beside the interface with plain signals
`timescale 1ns/1ps
module svc_props #(
  parameter int HOLD_CYC = 20
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ref_tick,
  input wire logic reset_pin,
  input wire logic [3:0] serial_port_rx,
  input wire logic [3:0] serial_port_tx,
  input wire logic fault_out_n_oe_n,
  input wire logic fault_out_n
);
  int hi_cnt_q;
  int lo_cnt_q;
  // high and low run lengths of the reset pin, saturating
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_q <= 0;
      lo_cnt_q <= 0;
    end else begin
      hi_cnt_q <= reset_pin ? hi_cnt_q + (hi_cnt_q < 100000) : 0;
      lo_cnt_q <= reset_pin ? 0 : lo_cnt_q + (lo_cnt_q < 100000);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_ref_period: assert property (
    $rose(ref_tick) |-> ##4 $rose(ref_tick))
    else $error("reference tick period is not four cycles");
  a_reset_hold: assert property (
    $fell(reset_pin) |-> hi_cnt_q >= HOLD_CYC)
    else $error("reset pin released too early");
  a_settle_gap: assert property (
    $rose(|serial_port_rx) |-> lo_cnt_q >= HOLD_CYC)
    else $error("port traffic before settle time");
  a_rx_quiet: assert property (reset_pin |-> serial_port_rx == 4'h0)
    else $error("port traffic during reset");
  a_fault_wire: assert property (
    fault_out_n == fault_out_n_oe_n)
    else $error("fault line does not follow its driver");
  a_tx_reset: assert property (
    $rose(reset_pin) |-> ##8 serial_port_tx == 4'h0)
    else $error("port answer not cleared by reset");
  c_reset_seq: cover property ($fell(reset_pin));
endmodule : svc_props

// File: test/tb_module_reset_boot_link_control.sv
// self-checking bench joining host and module ends over svc_if
// assumes a 50 ns core clock and a short reset hold parameter
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_module_reset_boot_link_control;
  import svc_pkg::*;
  localparam int HOLD = 20;
  logic core_clk = 1'b0, resetn = 1'b0, internal_error = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, h_rdata, d_rdata, v;
  logic h_wr = 1'b0, h_rd = 1'b0, d_wr = 1'b0, d_rd = 1'b0;
  logic booted, halted, bus_enable, irq, link_ready, ds_rst, ds_halt;
  logic ds_fault_n = 1'b1;
  logic [1:0] port_fast;
  logic [3:0] port_answer, tx_seen;
  logic [15:0] r = 16'hC972; // seed 51570
  int error_cnt = 0, n_checks = 0, i;
  svc_if link ();
  svc_host #(.HOLD_CYC(HOLD)) i_svc_host (.core_clk(core_clk),
    .resetn(resetn), .link(link), .addr(addr), .wdata(wdata), .wr(h_wr),
    .rd(h_rd), .rdata(h_rdata), .link_ready(link_ready),
    .tx_lanes_seen(tx_seen));
  svc_dev i_svc_dev (.core_clk(core_clk), .resetn(resetn), .link(link),
    .addr(addr), .wdata(wdata), .wr(d_wr), .rd(d_rd), .rdata(d_rdata),
    .internal_error(internal_error), .booted(booted), .halted(halted),
    .bus_enable(bus_enable), .port_fast(port_fast),
    .port_answer(port_answer), .downstream_reset_out(ds_rst),
    .downstream_halt_out(ds_halt), .downstream_fault_in_n(ds_fault_n),
    .irq(irq));
  svc_props #(.HOLD_CYC(HOLD)) i_svc_props (.core_clk(core_clk),
    .resetn(resetn), .ref_tick(link.ref_tick), .reset_pin(link.reset_pin),
    .serial_port_rx(link.serial_port_rx),
    .serial_port_tx(link.serial_port_tx),
    .fault_out_n_oe_n(link.fault_out_n_oe_n),
    .fault_out_n(link.fault_out_n));
  // pseudo-random source for the processor error input
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // one-cycle strobe; dev selects which end's port is used
  task automatic wr(input bit dev, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    if (dev) d_wr <= 1'b1;
    else h_wr <= 1'b1;
    @(posedge core_clk);
    d_wr <= 1'b0;
    h_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input bit dev, input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    if (dev) d_rd <= 1'b1;
    else h_rd <= 1'b1;
    @(posedge core_clk);
    d_rd <= 1'b0;
    h_rd <= 1'b0;
    #1 v = dev ? d_rdata : h_rdata;
  endtask : rd
  // bounded wait; a hang here counts as a mismatch
  task automatic wait_ready();
    for (i = 0; i < 300 && link_ready !== 1'b1; i++) @(posedge core_clk);
    `CHK(link_ready, 1'b1)
    repeat (12) @(posedge core_clk);
  endtask : wait_ready
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rd(1, `DS_STAT_ADDR);
    `CHK(v, {ST_BOOT_WAIT, 2'b00, 1'b1})
    `CHK(bus_enable, 1'b0)
    // every rate combination; pins pass a synchroniser first
    for (int k = 0; k < 4; k++) begin
      wr(0, `HOST_CTRL_ADDR, 8'(k << 2));
      repeat (8) @(posedge core_clk);
      `CHK(port_fast, 2'(k))
    end
    wr(1, `IRQ_MASK_ADDR, 8'h01);
    wr(0, `HOST_CTRL_ADDR, 8'h0D);
    wait_ready();
    `CHK(booted, 1'b1)
    `CHK(irq, 1'b1)
    wr(1, `IRQ_STAT_ADDR, 8'h01);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    // random processor errors reach the open-drain line
    for (int k = 0; k < 8; k++) begin
      r = lfsr(r);
      @(posedge core_clk) internal_error <= r[0];
      repeat (2) @(posedge core_clk);
      `CHK(link.fault_out_n, ~internal_error)
    end
    // a held error shows as a low wired line at the host
    @(posedge core_clk) internal_error <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(0, `HOST_STAT_ADDR);
    `CHK(v, {HS_READY, 2'b00, 1'b1, 1'b1})
    rd(1, `IRQ_STAT_ADDR);
    `CHK(v, 8'h04)
    @(posedge core_clk) internal_error <= 1'b0;
    wr(1, `DS_CTRL_ADDR, 8'h03);
    @(posedge core_clk);
    `CHK({ds_halt, ds_rst}, 2'b11)
    ds_fault_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(1, `DS_STAT_ADDR);
    `CHK(v[0], 1'b0)
    // analyse with reset stops the processor; it answers while halted
    wr(0, `HOST_CTRL_ADDR, 8'h0F);
    repeat (12) @(posedge core_clk);
    `CHK(halted, 1'b1)
    `CHK(booted, 1'b0)
    wait_ready();
    `CHK(halted, 1'b1)
    `CHK(port_answer, 4'hF)
    `CHK(tx_seen, 4'hF)
    rd(1, `IRQ_STAT_ADDR);
    `CHK(v, 8'h0E)
    // a reset without analyse clears the halt, then the module reboots
    wr(0, `HOST_CTRL_ADDR, 8'h0D);
    repeat (12) @(posedge core_clk);
    `CHK({halted, booted}, 2'b00)
    `CHK({ds_halt, ds_rst}, 2'b00)
    wait_ready();
    `CHK(booted, 1'b1)
    `CHK(irq, 1'b1)
    end_of_test();
  end
endmodule : tb_module_reset_boot_link_control
